// [pkg/cej_pkg.sv]
// constants, opcodes and state codes for the jump/flag/nonvolatile-read core slice
// Notes on behaviour
// - nonvolatile read loads accumulator, updates sign/nonzero
// - nonvolatile read: one byte, six cycles minimum, longer while data is late
// - nonvolatile read holds one return-stack entry
// - flag refresh sets sign and nonzero flags
// - flag refresh: accumulator untouched, one byte/cycle
// - jump loads program counter, flags untouched
// - relative jump 2B/3cyc, absolute 3B/4cyc
// - program counter spans whole 8 kB space
package cej_pkg;

  // widths
  localparam int unsigned PC_W_DEF   = 13;     // 8 kB program space
  localparam int unsigned EPR_AW_DEF = 6;      // nonvolatile word address width
  localparam int unsigned WORD_W     = 24;     // accumulator width
  localparam int unsigned SIGN_POS   = 23;     // sign bit position
  localparam int unsigned ACC_CNT    = 4;      // x, y, z, r

  // accumulator select codes (low two opcode bits)
  localparam logic [1:0] ACC_X = 2'h0;
  localparam logic [1:0] ACC_Y = 2'h1;
  localparam logic [1:0] ACC_Z = 2'h2;
  localparam logic [1:0] ACC_R = 2'h3;

  // opcode bytes; upper six bits for register forms
  localparam logic [5:0] OP_GETEPR_HI  = 6'h04; // 0x10..0x13
  localparam logic [5:0] OP_GETFLAG_HI = 6'h05; // 0x14..0x17
  localparam logic [7:0] OP_GOTO_REL   = 8'h20;
  localparam logic [7:0] OP_GOTO_ABS   = 8'h21;

  // timing in core cycles
  localparam int unsigned EPR_CYCLES = 6;
  localparam logic [2:0]  EPR_LAST   = 3'(EPR_CYCLES - 1); // cycles spent after decode

  // reset values
  localparam logic [23:0] ACC_RST = 24'h00_0000;

  // instruction classes
  typedef enum logic [2:0] {
    CLS_GETEPR  = 3'b000,
    CLS_GETFLAG = 3'b001,
    CLS_REL     = 3'b010,
    CLS_ABS     = 3'b011,
    CLS_BAD     = 3'b100
  } cej_class_type;

  // sequencer states
  typedef enum logic [2:0] {
    ST_FETCH = 3'b000,
    ST_REL   = 3'b001,
    ST_AHI   = 3'b010,
    ST_ALO   = 3'b011,
    ST_JMP   = 3'b100,
    ST_EPR   = 3'b101
  } cej_state_type;

  // opcode byte to instruction class
  function automatic cej_class_type op_class(input logic [7:0] op);
    if (op[7:2] == OP_GETEPR_HI)       op_class = CLS_GETEPR;
    else if (op[7:2] == OP_GETFLAG_HI) op_class = CLS_GETFLAG;
    else if (op == OP_GOTO_REL)        op_class = CLS_REL;
    else if (op == OP_GOTO_ABS)        op_class = CLS_ABS;
    else                               op_class = CLS_BAD;
  endfunction

endpackage

// [src/cej_core.sv]
// instruction sequencer for nonvolatile read, flag refresh and unconditional jump
`timescale 1ns/1ps
module cej_core #(
  parameter int unsigned PC_W   = cej_pkg::PC_W_DEF,    // program counter width
  parameter int unsigned EPR_AW = cej_pkg::EPR_AW_DEF   // nonvolatile address width
) (
  input  wire logic              ref_clk,      // core clock
  input  wire logic              sys_rst,      // async reset, high
  output logic [PC_W-1:0]        pmem_addr,    // program byte address
  input  wire logic [7:0]        pmem_data,    // program byte at pmem_addr
  input  wire logic [EPR_AW-1:0] ram_ptr,      // RAM address pointer
  output logic                   epr_req,      // nonvolatile read request
  output logic [EPR_AW-1:0]      epr_addr,     // nonvolatile word address
  input  wire logic              epr_ack,      // read data valid
  input  wire logic [23:0]       epr_rdata,    // read data
  input  wire logic              stack_free,   // a return-stack entry is free
  output logic                   stack_push,   // occupy one entry
  output logic                   stack_pop,    // release the entry
  output logic                   flag_sign,    // sign flag
  output logic                   flag_nonzero, // nonzero flag
  output logic [23:0]            acc_x,        // accumulators
  output logic [23:0]            acc_y,
  output logic [23:0]            acc_z,
  output logic [23:0]            acc_r,
  output logic                   instr_done,   // pulse after an instruction ends
  output logic                   bad_opcode    // pulse on unknown opcode
);

  // refuse widths the target arithmetic cannot serve
  if (PC_W < 13 || PC_W > 16) begin : g_pc_chk
    $error("PC_W must lie in 13..16");
  end
  if (EPR_AW < 1 || EPR_AW > 16) begin : g_aw_chk
    $error("EPR_AW must lie in 1..16");
  end

  // whole module state
  typedef struct packed {
    cej_pkg::cej_state_type st;    // sequencer state
    logic [PC_W-1:0]        pc;    // program counter
    logic [PC_W-1:0]        tgt;   // jump target being built
    logic [2:0]             cnt;   // cycles spent in read
    logic [1:0]             sel;   // selected accumulator
    logic [23:0]            rdat;  // captured read word
    logic                   got;   // read word captured
    logic [3:0][23:0]       acc;   // x, y, z, r
    logic                   fs;    // sign flag
    logic                   fz;    // nonzero flag
    logic [EPR_AW-1:0]      eaddr; // read address
    logic                   ereq;  // read outstanding
    logic                   push;  // stack occupy pulse
    logic                   pop;   // stack release pulse
    logic                   done;  // instruction end pulse
    logic                   bad;   // unknown opcode pulse
  } cej_core_type;

  cej_core_type q_r;    // registered state
  cej_core_type q_nxt;  // next state

  cej_pkg::cej_class_type cls;  // class of byte on the bus
  logic [23:0] fe_val;          // word fed to flag evaluation
  logic        fe_sign;         // its sign
  logic        fe_nz;           // its nonzero
  logic        rd_last;         // read completes this cycle
  logic [23:0] rd_word;         // word to load on completion

  assign cls = cej_pkg::op_class(pmem_data);

  // read completes in its sixth cycle once data has arrived
  assign rd_last = (q_r.st == cej_pkg::ST_EPR) && (q_r.cnt == cej_pkg::EPR_LAST) &&
                   (q_r.got || (q_r.ereq && epr_ack));
  assign rd_word = q_r.got ? q_r.rdat : epr_rdata;

  // flag source: read word during a read, else the selected accumulator
  assign fe_val = (q_r.st == cej_pkg::ST_EPR) ? rd_word : q_r.acc[pmem_data[1:0]];

  cej_flag_eval u_flag (
    .value   (fe_val),
    .sign    (fe_sign),
    .nonzero (fe_nz)
  );

  // next-state logic
  always_comb begin
    q_nxt      = q_r;
    q_nxt.push = 1'b0;
    q_nxt.pop  = 1'b0;
    q_nxt.done = 1'b0;
    q_nxt.bad  = 1'b0;
    unique case (q_r.st)
      cej_pkg::ST_FETCH: begin
        unique case (cls)
          cej_pkg::CLS_GETFLAG: begin
            // flags only, accumulator untouched, single cycle
            q_nxt.fs   = fe_sign;
            q_nxt.fz   = fe_nz;
            q_nxt.pc   = q_r.pc + PC_W'(1);
            q_nxt.done = 1'b1;
          end
          cej_pkg::CLS_GETEPR: begin
            // wait for a free stack entry, then occupy it
            if (stack_free) begin
              q_nxt.push  = 1'b1;
              q_nxt.sel   = pmem_data[1:0];
              q_nxt.eaddr = ram_ptr;
              q_nxt.ereq  = 1'b1;
              q_nxt.got   = 1'b0;
              q_nxt.cnt   = 3'h1;
              q_nxt.pc    = q_r.pc + PC_W'(1);
              q_nxt.st    = cej_pkg::ST_EPR;
            end
          end
          cej_pkg::CLS_REL: begin
            q_nxt.pc = q_r.pc + PC_W'(1);
            q_nxt.st = cej_pkg::ST_REL;
          end
          cej_pkg::CLS_ABS: begin
            q_nxt.pc = q_r.pc + PC_W'(1);
            q_nxt.st = cej_pkg::ST_AHI;
          end
          cej_pkg::CLS_BAD: begin
            // unknown byte skipped as a one-cycle no-op
            q_nxt.pc  = q_r.pc + PC_W'(1);
            q_nxt.bad = 1'b1;
          end
        endcase
      end
      cej_pkg::ST_REL: begin
        // signed offset from the byte after the instruction
        q_nxt.tgt = q_r.pc + PC_W'(1) + {{(PC_W-8){pmem_data[7]}}, pmem_data};
        q_nxt.st  = cej_pkg::ST_JMP;
      end
      cej_pkg::ST_AHI: begin
        // high target bits first
        q_nxt.tgt = {pmem_data[PC_W-9:0], 8'h00};
        q_nxt.pc  = q_r.pc + PC_W'(1);
        q_nxt.st  = cej_pkg::ST_ALO;
      end
      cej_pkg::ST_ALO: begin
        q_nxt.tgt[7:0] = pmem_data;
        q_nxt.st       = cej_pkg::ST_JMP;
      end
      cej_pkg::ST_JMP: begin
        // load target; flags stay as they are
        q_nxt.pc   = q_r.tgt;
        q_nxt.done = 1'b1;
        q_nxt.st   = cej_pkg::ST_FETCH;
      end
      cej_pkg::ST_EPR: begin
        // capture returned word, keep counting to the sixth cycle
        if (q_r.ereq && epr_ack) begin
          q_nxt.ereq = 1'b0;
          q_nxt.got  = 1'b1;
          q_nxt.rdat = epr_rdata;
        end
        if (q_r.cnt != cej_pkg::EPR_LAST) begin
          q_nxt.cnt = q_r.cnt + 3'h1;
        end
        if (rd_last) begin
          q_nxt.acc[q_r.sel] = rd_word;
          q_nxt.fs   = fe_sign;
          q_nxt.fz   = fe_nz;
          q_nxt.pop  = 1'b1;
          q_nxt.done = 1'b1;
          q_nxt.st   = cej_pkg::ST_FETCH;
        end
      end
      default: begin
        // illegal code recovers to fetch
        q_nxt.st = cej_pkg::ST_FETCH;
      end
    endcase
  end

  // state register
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      q_r      <= '0;
      q_r.st   <= cej_pkg::ST_FETCH;
      q_r.acc  <= {cej_pkg::ACC_CNT{cej_pkg::ACC_RST}};
    end else begin
      q_r <= q_nxt;
    end
  end

  // outputs straight from state flops
  assign pmem_addr    = q_r.pc;
  assign epr_req      = q_r.ereq;
  assign epr_addr     = q_r.eaddr;
  assign stack_push   = q_r.push;
  assign stack_pop    = q_r.pop;
  assign flag_sign    = q_r.fs;
  assign flag_nonzero = q_r.fz;
  assign acc_x        = q_r.acc[cej_pkg::ACC_X];
  assign acc_y        = q_r.acc[cej_pkg::ACC_Y];
  assign acc_z        = q_r.acc[cej_pkg::ACC_Z];
  assign acc_r        = q_r.acc[cej_pkg::ACC_R];
  assign instr_done   = q_r.done;
  assign bad_opcode   = q_r.bad;

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  logic st_fetch;
  assign st_fetch = (q_r.st == cej_pkg::ST_FETCH);

  sequence rel_start;
    st_fetch && cls == cej_pkg::CLS_REL;
  endsequence
  sequence abs_start;
    st_fetch && cls == cej_pkg::CLS_ABS;
  endsequence
  sequence epr_start;
    st_fetch && cls == cej_pkg::CLS_GETEPR && stack_free;
  endsequence
  sequence flag_start;
    st_fetch && cls == cej_pkg::CLS_GETFLAG;
  endsequence

  flag_one_cycle_a: assert property (flag_start |=> instr_done && pmem_addr == $past(q_r.pc) + PC_W'(1))
    else $error("flag refresh not one cycle");
  flag_value_a: assert property (flag_start |=> flag_sign == $past(fe_val[cej_pkg::SIGN_POS])
                                 && flag_nonzero == $past(|fe_val))
    else $error("flag refresh flags wrong");
  flag_keep_acc_a: assert property (flag_start |=> $stable(q_r.acc))
    else $error("flag refresh changed accumulator");
  rel_jump_len_a: assert property (rel_start |=> q_r.st == cej_pkg::ST_REL ##1 q_r.st == cej_pkg::ST_JMP
                                   ##1 st_fetch && instr_done)
    else $error("relative jump length wrong");
  abs_jump_len_a: assert property (abs_start |=> !instr_done[*3] ##1 instr_done && st_fetch)
    else $error("absolute jump length wrong");
  jump_flags_a: assert property (rel_start or abs_start |=> $stable({flag_sign, flag_nonzero})[*3])
    else $error("jump altered flags");
  jump_target_a: assert property (q_r.st == cej_pkg::ST_JMP |=> pmem_addr == $past(q_r.tgt))
    else $error("jump target not loaded");
  epr_push_a: assert property (epr_start |=> stack_push && epr_req && epr_addr == $past(ram_ptr))
    else $error("read did not occupy stack");
  epr_min_len_a: assert property (epr_start |=> !instr_done[*5])
    else $error("read shorter than six cycles");
  epr_hold_pc_a: assert property (q_r.st == cej_pkg::ST_EPR |=> $stable(pmem_addr))
    else $error("fetch advanced during read");
  epr_load_a: assert property (stack_pop |-> instr_done && $past(rd_last)
                               && q_r.acc[$past(q_r.sel)] == $past(rd_word))
    else $error("read word not loaded");

endmodule

// [src/cej_flag_eval.sv]
// sign and nonzero evaluation of one accumulator word
`timescale 1ns/1ps
module cej_flag_eval (
  input  wire logic [23:0] value,     // word under test
  output logic             sign,      // negative
  output logic             nonzero    // differs from zero
);
  // two's complement sign and any-bit-set
  always_comb begin
    sign    = value[cej_pkg::SIGN_POS];
    nonzero = |value;
  end
endmodule

// [tb/tb_cpu_eeprom_flag_jump_ops.sv]
// self-checking bench for the nonvolatile read, flag refresh and jump core slice
`timescale 1ns/1ps
module tb_cpu_eeprom_flag_jump_ops;
  typedef struct {
    logic [12:0]      pc;            // pc after the instruction
    logic             s;             // sign flag
    logic             nz;            // nonzero flag
    logic [3:0][23:0] acc;           // x, y, z, r
    int               cyc;           // cycles, 0 = not checked
  } cej_tbnote_type;

  logic              ref_clk;        // core clock
  logic              sys_rst;        // async reset
  logic [12:0]       pmem_addr;      // program address from core
  logic [7:0]        pmem_data;      // program byte
  logic [5:0]        ram_ptr;        // pointer seen by core
  logic              epr_req;        // read outstanding
  logic [5:0]        epr_addr;       // read address
  logic              epr_ack;        // read data valid
  logic [23:0]       epr_rdata;      // read data
  logic              stack_free;     // return-stack entry free
  logic              stack_push;     // entry taken
  logic              stack_pop;      // entry released
  logic              flag_sign;      // sign flag
  logic              flag_nonzero;   // nonzero flag
  logic [23:0]       accs [4];       // accumulators
  logic              instr_done;     // instruction end pulse
  logic              bad_opcode;     // unknown byte pulse
  logic [7:0]        prog [8192];    // program memory
  logic [23:0]       eprom [64];     // nonvolatile contents
  cej_tbnote_type    q [$];          // expected results, oldest first
  logic [12:0]       m_pc;           // model program counter
  logic [3:0][23:0]  m_acc;          // model accumulators
  logic              m_s;            // model sign
  logic              m_nz;           // model nonzero
  int                pend;           // extra cycles owed to next note
  int                num_errors;     // mismatches
  int                check_count;    // comparisons
  int                cyc;            // cycle count
  int                last;           // cycle of previous done
  int                n_push;         // pushes seen
  int                n_pop;          // pops seen
  int                n_bad;          // bad opcodes seen
  int                n_epr;          // reads issued

  cej_core DUT (
    .ref_clk      (ref_clk),
    .sys_rst      (sys_rst),
    .pmem_addr    (pmem_addr),
    .pmem_data    (pmem_data),
    .ram_ptr      (ram_ptr),
    .epr_req      (epr_req),
    .epr_addr     (epr_addr),
    .epr_ack      (epr_ack),
    .epr_rdata    (epr_rdata),
    .stack_free   (stack_free),
    .stack_push   (stack_push),
    .stack_pop    (stack_pop),
    .flag_sign    (flag_sign),
    .flag_nonzero (flag_nonzero),
    .acc_x        (accs[0]),
    .acc_y        (accs[1]),
    .acc_z        (accs[2]),
    .acc_r        (accs[3]),
    .instr_done   (instr_done),
    .bad_opcode   (bad_opcode)
  );

  // combinational program memory; pointer follows the program address
  assign #1 pmem_data = prog[pmem_addr];
  assign #1 ram_ptr = pmem_addr[5:0] ^ 6'h2a;

  // clock, 20 ns period
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // nonvolatile memory: delay taken from address, garbage outside ack
  initial begin : responder
    int wt;
    int dl;
    epr_ack = 1'b0;
    epr_rdata = 24'h00_0000;
    wt = 0;
    forever begin
      @(posedge ref_clk);
      #1;
      epr_ack = 1'b0;
      epr_rdata = ~epr_rdata;
      dl = epr_addr[2] ? 7 : int'(epr_addr[1:0]);
      if (epr_req && wt >= 0) begin
        if (wt == dl) begin
          epr_ack = 1'b1;
          epr_rdata = eprom[epr_addr];
          wt = -1;
        end else begin
          wt++;
        end
      end
      if (!epr_req) wt = 0;
    end
  end

  // one stall of five cycles on the read at address 1
  initial begin : staller
    int hold;
    hold = 0;
    stack_free = 1'b1;
    forever begin
      @(posedge ref_clk);
      #1;
      stack_free = !(pmem_addr == 13'h0001 && !sys_rst && hold < 5);
      if (!stack_free) hold++;
    end
  end

  // value comparison
  task automatic chk_val(input string what, input logic [23:0] exp, input logic [23:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // count comparison
  task automatic chk_cnt(input string what, input int exp, input int got);
    check_count++;
    if (got != exp) begin
      num_errors++;
      $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  // program builders keep the model and note the expectation
  task automatic put(input logic [7:0] b);
    prog[m_pc] = b;
    m_pc = m_pc + 13'h0001;
  endtask
  task automatic note(input int c);
    q.push_back('{m_pc, m_s, m_nz, m_acc, (c < 0) ? 0 : c + pend});
    pend = 0;
  endtask
  task automatic setf(input logic [23:0] w);
    m_s = w[23];
    m_nz = (w != 24'h00_0000);
  endtask
  task automatic i_read(input logic [1:0] sel, input int extra, input int first);
    logic [5:0] a;
    a = m_pc[5:0] ^ 6'h2a;
    put(8'h10 | 8'(sel));
    m_acc[sel] = eprom[a];
    setf(eprom[a]);
    n_epr++;
    note(first ? -1 : ((a[2] ? 9 : 6) + extra));
  endtask
  task automatic i_flag(input logic [1:0] sel, input int first);
    put(8'h14 | 8'(sel));
    setf(m_acc[sel]);
    note(first ? -1 : 1);
  endtask
  task automatic i_rel(input logic [7:0] off);
    put(8'h20);
    put(off);
    m_pc = m_pc + {{5{off[7]}}, off};
    note(3);
  endtask
  task automatic i_abs(input logic [12:0] t);
    put(8'h21);
    put({3'h0, t[12:8]});
    put(t[7:0]);
    m_pc = t;
    note(4);
  endtask

  // result watcher
  always @(negedge ref_clk) begin : watcher
    cej_tbnote_type n;
    if (!sys_rst) begin
      cyc++;
      n_push += int'(stack_push);
      n_pop += int'(stack_pop);
      n_bad += int'(bad_opcode);
      if (instr_done && q.size() > 0) begin
        n = q.pop_front();
        chk_val("pc", 24'(n.pc), 24'(pmem_addr));
        chk_val("sign", 24'(n.s), 24'(flag_sign));
        chk_val("nonzero", 24'(n.nz), 24'(flag_nonzero));
        for (int i = 0; i < 4; i++) chk_val("acc", n.acc[i], accs[i]);
        if (n.cyc != 0) chk_cnt("cycles", n.cyc, cyc - last);
      end
      if (instr_done) last = cyc;
    end
  end

  // verdict
  task automatic tally_and_finish();
    if (num_errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // build the program, run it, wait for every note
  initial begin
    int i;
    void'($urandom(11));
    {num_errors, check_count, cyc, last, n_push, n_pop, n_bad, n_epr, pend} = '0;
    {m_pc, m_acc, m_s, m_nz} = '0;
    sys_rst = 1'b1;
    foreach (prog[k]) prog[k] = 8'h14;
    foreach (eprom[k]) eprom[k] = ($urandom % 4 == 0) ? 24'h00_0000 : 24'($urandom);
    i_flag(2'h0, 1);
    i_read(2'h1, 5, 0);
    for (i = 0; i < 30; i++) begin
      case ($urandom % 4)
        0: i_read(2'($urandom), 0, 0);
        1: i_flag(2'($urandom), 0);
        2: i_rel(8'($urandom % 128));
        default: i_abs(m_pc + 13'd3 + 13'($urandom % 200));
      endcase
    end
    put(8'hff);
    pend = 1;
    i_read(2'h3, 0, 0);
    i_abs(13'h1f00);
    i_rel(8'h80);
    i_abs(13'h1ffc);
    i_flag(2'h3, 0);
    // closing self loop keeps the core away from further reads
    i_rel(8'hfe);
    repeat (16) @(posedge ref_clk);
    #1 sys_rst = 1'b0;
    for (i = 0; i < 20000 && q.size() > 0; i++) @(posedge ref_clk);
    if (q.size() > 0) begin
      num_errors++;
      $display("[FAIL] completion expected %0d seen %0d", 0, q.size());
    end
    repeat (2) @(posedge ref_clk);
    chk_cnt("pushes", n_epr, n_push);
    chk_cnt("pops", n_epr, n_pop);
    chk_cnt("bad", 1, n_bad);
    tally_and_finish();
  end
endmodule
